// ---- hw/dcwd_top.v ----
// drive control word decoder: enable states, runs, jog, fault handling
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_consts.vh"

module dcwd_top #(
	parameter W = `DCWD_WIDTH
) (
	input  wire         sys_clk,
	input  wire         rst,
	input  wire         cmdValid,
	input  wire [W-1:0] cmdWord,
	input  wire         driveError,
	input  wire         targetReached,
	input  wire         rangeEndReached,
	output reg  [W-1:0] statusWord,
	output reg          runPosition,
	output reg          runSpeed,
	output reg          runPaused,
	output reg          runClockwise,
	output reg          runEndless,
	output reg          runStartPulse,
	output reg          jog1Run,
	output reg          jog2Run,
	output reg          faultAckPulse
);
	// =====================================================
	// command word capture and edges
	// =====================================================
	reg  [W-1:0] word_q;
	reg          stb_q;
	wire [W-1:0] prevWord;
	wire [W-1:0] riseBits;
	wire [W-1:0] fallBits;

	always @(posedge sys_clk) begin
		if (rst) begin
			word_q <= `DCWD_CW_RESET;
			stb_q  <= 1'b0;
		end else begin
			stb_q <= cmdValid;
			if (cmdValid)
				word_q <= cmdWord;
		end
	end

	dcwd_edge #(
		.W(W)
	) uEdge (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wordStb (stb_q),
		.wordIn  (word_q),
		.prevWord(prevWord),
		.riseBits(riseBits),
		.fallBits(fallBits)
	);

	// =====================================================
	// enable state machine
	// =====================================================
	wire stRdyOn;
	wire stRdyOp;
	wire stOpEn;
	wire stFault;
	wire stInhibit;
	wire fackFall;

	assign fackFall = fallBits[`DCWD_CW_FACK];

	dcwd_enable_fsm uFsm (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.wordStb  (stb_q),
		.word     (word_q),
		.errorIn  (driveError),
		.fackFall (fackFall),
		.stRdyOn  (stRdyOn),
		.stRdyOp  (stRdyOp),
		.stOpEn   (stOpEn),
		.stFault  (stFault),
		.stInhibit(stInhibit)
	);

	// =====================================================
	// run control
	// =====================================================
	// reserved bits 1, 2, 11, 13..15 are ignored; host keeps them 0
	wire cNoStop;
	wire cNoPause;
	wire cTog;
	wire cSpeed;
	reg  ack_q;
	reg  atTgt_q;
	reg  warn_q;
	wire posStart;
	wire spdStart;
	wire spdStop;

	assign cNoStop = word_q[`DCWD_CW_NOSTOP];
	assign cNoPause = word_q[`DCWD_CW_NOPAUSE];
	assign cTog = word_q[`DCWD_CW_RUNTOG];
	assign cSpeed = word_q[`DCWD_CW_SPEED];

	// toggle handshake against acknowledge bit
	assign posStart = stb_q && stOpEn && !cSpeed && cNoStop
		&& (cTog != ack_q) && !runPosition && !runSpeed;
	// speed runs on edges of bit 6
	assign spdStart = stb_q && stOpEn && cSpeed
		&& riseBits[`DCWD_CW_RUNTOG] && !runPosition;
	assign spdStop = stb_q && fallBits[`DCWD_CW_RUNTOG];

	always @(posedge sys_clk) begin
		if (rst) begin
			runPosition   <= 1'b0;
			runSpeed      <= 1'b0;
			runPaused     <= 1'b0;
			runClockwise  <= 1'b0;
			runEndless    <= 1'b0;
			runStartPulse <= 1'b0;
			ack_q         <= 1'b0;
			atTgt_q       <= 1'b0;
		end else begin
			runStartPulse <= posStart | spdStart;
			if (!stOpEn) begin
				runPosition <= 1'b0;
				runSpeed    <= 1'b0;
				runPaused   <= 1'b0;
			end else begin
				if (posStart) begin
					runPosition <= 1'b1;
					runPaused   <= !cNoPause;
					ack_q       <= cTog;
					atTgt_q     <= 1'b0;
				end else if (runPosition) begin
					// a finished or aborted run is never left paused
					if (!cNoStop) begin
						runPosition <= 1'b0;
						runPaused   <= 1'b0;
					end else if (targetReached) begin
						runPosition <= 1'b0;
						runPaused   <= 1'b0;
						atTgt_q     <= 1'b1;
					end else
						runPaused <= !cNoPause;
				end
				if (spdStart) begin
					runSpeed     <= 1'b1;
					ack_q        <= cTog;
					runClockwise <= cNoStop;
					runEndless   <= cNoPause;
				end else if (runSpeed) begin
					if (spdStop)
						runSpeed <= 1'b0;
					else if (!runEndless && rangeEndReached)
						runSpeed <= 1'b0;
				end
			end
			if (!stRdyOp && !stFault && !stInhibit) begin
				ack_q   <= 1'b0;
				atTgt_q <= 1'b0;
			end
		end
	end

	// =====================================================
	// jog, fault acknowledge, warning
	// =====================================================
	always @(posedge sys_clk) begin
		if (rst) begin
			jog1Run       <= 1'b0;
			jog2Run       <= 1'b0;
			faultAckPulse <= 1'b0;
			warn_q        <= 1'b0;
		end else begin
			jog1Run <= stOpEn && word_q[`DCWD_CW_JOG1]
				&& !runPosition && !runSpeed;
			jog2Run <= stOpEn && word_q[`DCWD_CW_JOG2]
				&& !word_q[`DCWD_CW_JOG1]
				&& !runPosition && !runSpeed;
			faultAckPulse <= fackFall && stFault;
			if (driveError)
				warn_q <= 1'b1;
			else if (!stFault)
				warn_q <= 1'b0;
		end
	end

	// =====================================================
	// status word
	// =====================================================
	always @(posedge sys_clk) begin
		if (rst) begin
			statusWord <= {W{1'b0}};
		end else begin
			statusWord <= {W{1'b0}};
			statusWord[`DCWD_ST_RDYON]   <= stRdyOn;
			statusWord[`DCWD_ST_RDYOP]   <= stRdyOp;
			statusWord[`DCWD_ST_OPEN]    <= stOpEn;
			statusWord[`DCWD_ST_FAULT]   <= stFault;
			statusWord[`DCWD_ST_INHIBIT] <= stInhibit;
			statusWord[`DCWD_ST_WARN]    <= warn_q;
			// masked by state so a drop below ready-op clears at once
			statusWord[`DCWD_ST_ATTGT]   <= atTgt_q
				&& (stRdyOp || stFault || stInhibit);
			statusWord[`DCWD_ST_ACK]     <= ack_q
				&& (stRdyOp || stFault || stInhibit);
			statusWord[`DCWD_ST_STILL]   <= !runPosition && !runSpeed;
		end
	end
endmodule
`default_nettype wire

// ---- inc/dcwd_consts.vh ----
// constants for the drive control word decoder
`ifndef DCWD_CONSTS_VH
`define DCWD_CONSTS_VH

// control word bit positions
`define DCWD_CW_ON          0
`define DCWD_CW_COAST_INH   1
`define DCWD_CW_QUICK_INH   2
`define DCWD_CW_OPEN        3
`define DCWD_CW_NOSTOP      4
`define DCWD_CW_NOPAUSE     5
`define DCWD_CW_RUNTOG      6
`define DCWD_CW_FACK        7
`define DCWD_CW_JOG1        8
`define DCWD_CW_JOG2        9
`define DCWD_CW_CTRL        10
`define DCWD_CW_HOME        11
`define DCWD_CW_SPEED       12

// status word bit positions
`define DCWD_ST_RDYON       0
`define DCWD_ST_RDYOP       1
`define DCWD_ST_OPEN        2
`define DCWD_ST_FAULT       3
`define DCWD_ST_INHIBIT     6
`define DCWD_ST_WARN        7
`define DCWD_ST_ATTGT       10
`define DCWD_ST_ACK         12
`define DCWD_ST_STILL       13

// reset value and word width
`define DCWD_CW_RESET       16'h0000
`define DCWD_WIDTH          16

`endif

// ---- hw/dcwd_edge.v ----
// previous-word store and per-bit edge detection of the control word
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_consts.vh"

module dcwd_edge #(
	parameter W = `DCWD_WIDTH
) (
	input  wire         sys_clk,
	input  wire         rst,
	input  wire         wordStb,
	input  wire [W-1:0] wordIn,
	output wire [W-1:0] prevWord,
	output wire [W-1:0] riseBits,
	output wire [W-1:0] fallBits
);
	reg [W-1:0] prev_q;

	// compare only on a cyclic update
	always @(posedge sys_clk) begin
		if (rst)
			prev_q <= `DCWD_CW_RESET;
		else if (wordStb)
			prev_q <= wordIn;
	end

	assign prevWord = prev_q;
	assign riseBits = wordStb ? (wordIn & ~prev_q) : {W{1'b0}};
	assign fallBits = wordStb ? (~wordIn & prev_q) : {W{1'b0}};
endmodule
`default_nettype wire

// ---- hw/dcwd_enable_fsm.v ----
// enable state machine of the drive
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_consts.vh"

module dcwd_enable_fsm (
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       wordStb,
	input  wire [15:0] word,
	input  wire       errorIn,
	input  wire       fackFall,
	output wire       stRdyOn,
	output wire       stRdyOp,
	output wire       stOpEn,
	output wire       stFault,
	output wire       stInhibit
);
	localparam [5:0] S_NRDY  = 6'h01;
	localparam [5:0] S_RDYON = 6'h02;
	localparam [5:0] S_RDYOP = 6'h04;
	localparam [5:0] S_OPEN  = 6'h08;
	localparam [5:0] S_FAULT = 6'h10;
	localparam [5:0] S_INHIB = 6'h20;

	reg [5:0] state_q;
	reg [5:0] state_d;
	wire      cOn;
	wire      cOp;
	wire      cCtl;
	wire      atLeastOp;

	assign cOn = word[`DCWD_CW_ON];
	assign cOp = word[`DCWD_CW_OPEN];
	assign cCtl = word[`DCWD_CW_CTRL];
	assign atLeastOp = state_q[2] | state_q[3];

	always @* begin
		state_d = state_q;
		case (state_q)
		S_NRDY: begin
			if (wordStb && cCtl)
				state_d = S_RDYON;
		end
		S_RDYON: begin
			if (wordStb && !cCtl)
				state_d = S_NRDY;
			else if (wordStb && cOn)
				state_d = S_RDYOP;
		end
		S_RDYOP: begin
			if (errorIn)
				state_d = S_FAULT;
			else if (wordStb && !cCtl)
				state_d = S_NRDY;
			else if (wordStb && !cOn)
				state_d = S_RDYON;
			else if (wordStb && cOp)
				state_d = S_OPEN;
		end
		S_OPEN: begin
			if (errorIn)
				state_d = S_FAULT;
			else if (wordStb && !cCtl)
				state_d = S_NRDY;
			else if (wordStb && !cOn)
				state_d = S_RDYON;
			else if (wordStb && !cOp)
				state_d = S_RDYOP;
		end
		S_FAULT: begin
			if (fackFall)
				state_d = S_INHIB;
		end
		S_INHIB: begin
			if (wordStb && !cOn)
				state_d = cCtl ? S_RDYON : S_NRDY;
		end
		default: state_d = S_NRDY;
		endcase
	end

	always @(posedge sys_clk) begin
		if (rst)
			state_q <= S_NRDY;
		else
			state_q <= state_d;
	end

	assign stRdyOn = state_q[1] | atLeastOp;
	assign stRdyOp = atLeastOp;
	assign stOpEn = state_q[3];
	assign stFault = state_q[4];
	assign stInhibit = state_q[5];
endmodule
`default_nettype wire

// ---- sim/dcwd_top_props.sv ----
// checker bound to the decoder ports
`timescale 1ns/1ps
`default_nettype none
module dcwd_top_props #(
	parameter W = 16
) (
	input wire logic         sys_clk,
	input wire logic         rst,
	input wire logic         cmdValid,
	input wire logic [W-1:0] cmdWord,
	input wire logic [W-1:0] statusWord,
	input wire logic         runPosition,
	input wire logic         runSpeed,
	input wire logic         runPaused,
	input wire logic         runStartPulse,
	input wire logic         faultAckPulse
);
	default clocking dcwdClk @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	start_pulse_a: assert property (runStartPulse |=> !runStartPulse)
		else $error("start pulse too long");
	ack_pulse_a: assert property (faultAckPulse |=> !faultAckPulse)
		else $error("ack pulse too long");
	run_excl_a: assert property (!(runPosition && runSpeed))
		else $error("both run kinds active");
	start_tgt_a: assert property (runStartPulse && runPosition
		|=> !statusWord[10]) else $error("target flag kept");
	pause_pos_a: assert property (runPaused |-> runPosition)
		else $error("pause without run");
	ack_low_a: assert property (!statusWord[0] && !statusWord[3] &&
		!statusWord[6] |-> !statusWord[12]) else $error("ack kept");
	ctrl_drop_a: assert property (cmdValid && !cmdWord[10] |->
		##3 !statusWord[2]) else $error("enable kept");
	fault_op_a: assert property (statusWord[3] |-> !statusWord[2])
		else $error("fault while enabled");
endmodule
bind dcwd_top dcwd_top_props #(.W(W)) dcwd_top_props_i (.sys_clk(sys_clk),
	.rst(rst), .cmdValid(cmdValid), .cmdWord(cmdWord),
	.statusWord(statusWord), .runPosition(runPosition),
	.runSpeed(runSpeed), .runPaused(runPaused),
	.runStartPulse(runStartPulse), .faultAckPulse(faultAckPulse));
`default_nettype wire

// ---- sim/dcwd_scanner.sv ----
// scanner model issuing cyclic control words
`timescale 1ns/1ps
`default_nettype none
module dcwd_scanner (
	input  wire logic        sys_clk,
	input  wire logic [15:0] statusWord,
	output var  logic        cmdValid,
	output var  logic [15:0] cmdWord,
	output var  logic        timedOut
);
	logic [15:0] lastQ;
	initial {cmdValid, cmdWord, timedOut, lastQ} = 34'h000000000;
	task automatic send(input logic [15:0] w);
		logic [15:0] v;
		int n;
		v = w & 16'h17F9; // reserved bits low
		n = 0;
		while (!v[12] && v[6] != lastQ[6] && statusWord[12] !== lastQ[6]
				&& n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		timedOut = (n == 50);
		@(posedge sys_clk) cmdValid <= 1'b1;
		cmdWord <= v;
		@(posedge sys_clk) cmdValid <= 1'b0;
		cmdWord <= ~v; // no stale word once released
		lastQ = v;
	endtask
endmodule
`default_nettype wire

// ---- sim/dcwd_top_tb.sv ----
// self-checking bench for the control word decoder
`timescale 1ns/1ps
`default_nettype none
module dcwd_top_tb;
	logic        sys_clk, rst, cmdValid, driveError, targetReached;
	logic        rangeEndReached, runPosition, runSpeed, runPaused;
	logic        runClockwise, runEndless, runStartPulse, jog1Run, jog2Run;
	logic        faultAckPulse, timedOut;
	logic        ackSeen = 1'b0;
	logic [15:0] cmdWord, statusWord;
	int          failures = 0, cmp_count = 0;
	dcwd_top dcwd_top_i (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid),
		.cmdWord(cmdWord), .driveError(driveError),
		.targetReached(targetReached), .rangeEndReached(rangeEndReached),
		.statusWord(statusWord), .runPosition(runPosition),
		.runSpeed(runSpeed), .runPaused(runPaused),
		.runClockwise(runClockwise), .runEndless(runEndless),
		.runStartPulse(runStartPulse), .jog1Run(jog1Run),
		.jog2Run(jog2Run), .faultAckPulse(faultAckPulse));
	dcwd_scanner dcwd_scanner_i (.sys_clk(sys_clk), .statusWord(statusWord),
		.cmdValid(cmdValid), .cmdWord(cmdWord), .timedOut(timedOut));
	initial forever #2.5 sys_clk = ~sys_clk;
	// catches the one-cycle acknowledge pulse
	always @(posedge sys_clk) if (faultAckPulse) ackSeen <= 1'b1;
	task automatic check(input string what, input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic settle;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic send(input logic [15:0] w);
		dcwd_scanner_i.send(w);
		if (timedOut) begin
			failures++;
			results();
		end
		settle();
	endtask
	task automatic stat(input logic [15:0] m, e);
		check("status", statusWord & m, e);
	endtask
	task automatic flg(input logic [4:0] e);
		check("flags", 16'({runPosition, runSpeed, runPaused, jog1Run,
			jog2Run}), 16'(e));
	endtask
	task automatic enable_seq;
		send(16'h0400);
		stat(16'h0007, 16'h0001);
		send(16'h0401);
		stat(16'h0007, 16'h0003);
		send(16'h0409);
		stat(16'h0007, 16'h0007);
	endtask
	task automatic pos_run;
		send(16'h0479);
		flg(5'h10);
		stat(16'h1400, 16'h1000);
		send(16'h0459);
		flg(5'h14);
		send(16'h0479);
		flg(5'h10);
		@(posedge sys_clk) targetReached <= 1'b1;
		@(posedge sys_clk) targetReached <= 1'b0;
		settle();
		stat(16'h0400, 16'h0400);
		send(16'h0439);
		stat(16'h1400, 16'h0000);
		send(16'h0429);
		flg(5'h00);
	endtask
	task automatic jog_seq;
		send(16'h0709);
		flg(5'h02);
		send(16'h0609);
		flg(5'h01);
		send(16'h0409);
	endtask
	task automatic speed_run(input logic cw, en);
		logic [15:0] w;
		w = 16'h1449 | {10'h000, en, cw, 4'h0};
		send(w);
		flg(5'h08);
		check("dir", 16'({runClockwise, runEndless}), 16'({cw, en}));
		@(posedge sys_clk) rangeEndReached <= 1'b1;
		settle();
		flg(en ? 5'h08 : 5'h00);
		@(posedge sys_clk) rangeEndReached <= 1'b0;
		send(w ^ 16'h0040);
		flg(5'h00);
	endtask
	task automatic fault_seq;
		@(posedge sys_clk) driveError <= 1'b1;
		settle();
		stat(16'h0008, 16'h0008);
		@(posedge sys_clk) driveError <= 1'b0;
		send(16'h0489);
		check("fack", 16'(ackSeen), 16'h0000);
		send(16'h0409);
		stat(16'h0048, 16'h0040);
		check("fack", 16'(ackSeen), 16'h0001);
		send(16'h0408);
		stat(16'h1047, 16'h0001);
		send(16'h0000);
		stat(16'h0007, 16'h0000);
	endtask
	initial begin
		sys_clk = 1'b0;
		{rst, driveError, targetReached, rangeEndReached} = 4'h8;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		stat(16'hFFFF, 16'h0000);
		enable_seq();
		pos_run();
		jog_seq();
		speed_run(1'b1, 1'b0);
		speed_run(1'b0, 1'b1);
		fault_seq();
		results();
	end
endmodule
`default_nettype wire
